//--- cff_pkg.sv
// Shared constants and decode helpers for the loop fault flag register block
package cff_pkg;
	localparam int ADDR_W = 12;
	localparam int IDX_W = 6;
	// Register indices; byte address is four times the index
	localparam logic [5:0] IDX_LOOP_FLAGS = 6'h13;
	localparam logic [5:0] IDX_CAL_FLAGS = 6'h14;
	localparam logic [5:0] IDX_DEV_MASK = 6'h17;
	localparam logic [5:0] IDX_IN_MASK = 6'h18;
	localparam logic [5:0] IDX_LOOP_MASK = 6'h19;
	localparam logic [5:0] IDX_CAL_MASK = 6'h1a;
	localparam logic [5:0] IDX_SOFT_RST = 6'h1c;
	localparam logic [5:0] IDX_STEP = 6'h1d;
	localparam logic [5:0] IDX_CTRL = 6'h1e;
	// Field positions
	localparam int SR_DEVICE = 0;
	localparam int SR_LOOP_LO = 1;
	localparam int STEP_UP_BIT = 0;
	localparam int STEP_DOWN_BIT = 1;
	localparam int CTL_SLEEP = 0;
	localparam int CTL_HARD = 1;
	localparam int CTL_ALIGN = 2;
	localparam int CAL_LO = 4;
	localparam logic [7:0] DEV_MASK_USED = 8'h2f;
	// Reset values
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic RST_SLEEP = 1'h0;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
		logic [5:0] idx;
		idx = addr[7:2];
		if (addr[ADDR_W-1:8] != 4'h0) begin
			return 1'b0;
		end
		unique case (idx)
			IDX_LOOP_FLAGS, IDX_CAL_FLAGS, IDX_DEV_MASK, IDX_IN_MASK, IDX_LOOP_MASK,
			IDX_CAL_MASK, IDX_SOFT_RST, IDX_STEP, IDX_CTRL: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : reg_mapped
endpackage : cff_pkg

//--- cff_reg_if.sv
// Internal register access port between the bus slave and the register bank
`timescale 1ns/1ps
interface cff_reg_if;
	logic wr_en;
	logic [5:0] wr_idx;
	logic [7:0] wr_data;
	logic [5:0] rd_idx;
	logic [7:0] rd_data;
	modport slave (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
	modport bank (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : cff_reg_if

//--- cff_sticky.sv
// Bank of sticky fault flags cleared by writing zero while the live bit is low
`timescale 1ns/1ps
module cff_sticky #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] live,
	input wire logic clr_req,
	input wire logic [W-1:0] clr_data,
	output logic [W-1:0] flags
);
	logic [W-1:0] clr_bits;

	// Only zeros clear, and only where the live bit is already low
	assign clr_bits = clr_req ? (~clr_data & ~live) : '0;

	// Live wins over a clear landing in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= '0;
		end else begin
			flags <= (flags & ~clr_bits) | live;
		end
	end

	a_live_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		(live != '0) |=> ((flags & $past(live)) == $past(live)))
		else $error("live condition did not set its sticky flag");
	a_clear_guard: assert property (@(posedge aclk) disable iff (!aresetn)
		(($past(flags) & ~flags & ($past(live) | ~{W{$past(clr_req)}} | $past(clr_data)))
		== '0))
		else $error("sticky flag fell without a permitted clear");
endmodule : cff_sticky

//--- cff_axil.sv
// AXI4-Lite slave front end feeding the internal register port
`timescale 1ns/1ps
module cff_axil (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [cff_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [cff_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	cff_reg_if.slave rb
);
	logic aw_full;
	logic w_full;
	logic [cff_pkg::ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte;
	logic w_lane0;
	logic do_write;
	logic wr_hit;
	logic rd_hit;

	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_hit = cff_pkg::reg_mapped(aw_addr);
	assign rd_hit = cff_pkg::reg_mapped(s_axi_araddr);
	// Upper byte lanes carry nothing; lane 0 must be strobed to write
	assign rb.wr_en = do_write && wr_hit && w_lane0;
	assign rb.wr_idx = aw_addr[7:2];
	assign rb.wr_data = w_byte;
	assign rb.rd_idx = s_axi_araddr[7:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_full <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full <= 1'b0;
			w_byte <= 8'h00;
			w_lane0 <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_full <= 1'b1;
			w_byte <= s_axi_wdata[7:0];
			w_lane0 <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_full <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cff_pkg::RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? cff_pkg::RESP_OKAY : cff_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= cff_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_hit ? {24'h00_0000, rb.rd_data} : 32'h0000_0000;
			s_axi_rresp <= rd_hit ? cff_pkg::RESP_OKAY : cff_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	a_read_latency: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer not given one cycle after address");
	a_bresp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
endmodule : cff_axil

//--- cff_top.sv
// Fault flag, interrupt mask and reset strobe register block for four loops
// Contract
// - Sticky unlock flag per loop, bits 3:0
// - Sticky holdover flag per loop, bits 7:4
// - Writing zero clears a set flag only
// - Clear ignored while live status still high
// - Sticky calibration-busy flag per loop, bits 7:4
// - Device mask bits block device flag interrupts
// - Input mask bits block absent/wrong-frequency interrupts
// - Loop mask bits block unlock/holdover interrupts
// - Calibration mask bits block calibration-busy interrupts
// - Bit 0 restarts whole device, no reload
// - Bits 1-4 restart one loop, self-clearing
// - Whole restart also applies strobed settings
// - Loop restart does not apply bandwidth
// - Write one steps frequency unless step-blocked
// - Control bit 0 selects low-current sleep
// - Control bit 1 hard resets with reload
// - Control bit 2 aligns dividers like pin
// - Unlock flags track live unlock status bits
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module cff_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [cff_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [cff_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] unlocked,
	input wire logic [3:0] holdover,
	input wire logic [3:0] calibrating,
	input wire logic divider_align_pin_n,
	input wire logic [7:0] device_sticky_flags,
	input wire logic [7:0] input_sticky_flags,
	input wire logic [2:0] step_block_bits,
	output logic irq_out_n,
	output logic device_restart,
	output logic settings_apply,
	output logic [3:0] loop_restart,
	output logic [2:0] step_up_strobe,
	output logic [2:0] step_down_strobe,
	output logic low_current_sleep,
	output logic hard_reload,
	output logic divider_align
);
	cff_reg_if rb ();

	logic [12:0] meta;
	logic [12:0] synced;
	logic [3:0] unlocked_s;
	logic [3:0] holdover_s;
	logic [3:0] calibrating_s;
	logic align_pin_n_s;
	logic [7:0] loop_flags;
	logic [3:0] cal_flags;
	logic [7:0] dev_mask;
	logic [7:0] in_mask;
	logic [7:0] loop_mask;
	logic [3:0] cal_mask;
	logic wr_loop_flags;
	logic wr_cal_flags;
	logic wr_soft;
	logic wr_step;
	logic wr_ctrl;
	logic hard_clear;
	logic [7:0] dev_pending;
	logic [7:0] in_pending;
	logic [7:0] loop_pending;
	logic [3:0] cal_pending;
	logic next_irq;

	function automatic logic wr_to(input logic en, input logic [5:0] idx,
		input logic [5:0] target);
		return en && (idx == target);
	endfunction : wr_to

	cff_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rb(rb.slave)
	);

	// Loop status and the align pin come from other domains
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= 13'h1000;
			synced <= 13'h1000;
		end else begin
			meta <= {divider_align_pin_n, calibrating, holdover, unlocked};
			synced <= meta;
		end
	end

	assign unlocked_s = synced[3:0];
	assign holdover_s = synced[7:4];
	assign calibrating_s = synced[11:8];
	assign align_pin_n_s = synced[12];

	assign wr_loop_flags = wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_LOOP_FLAGS);
	assign wr_cal_flags = wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_CAL_FLAGS);
	assign wr_soft = wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_SOFT_RST);
	assign wr_step = wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_STEP);
	assign wr_ctrl = wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_CTRL);

	// Sticky flags mirror and clear against the live status bits
	cff_sticky #(.W(8)) u_loop_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.live({holdover_s, unlocked_s}),
		.clr_req(wr_loop_flags),
		.clr_data(rb.wr_data),
		.flags(loop_flags)
	);

	cff_sticky #(.W(4)) u_cal_flags (
		.aclk(aclk),
		.aresetn(aresetn),
		.live(calibrating_s),
		.clr_req(wr_cal_flags),
		.clr_data(rb.wr_data[7:cff_pkg::CAL_LO]),
		.flags(cal_flags)
	);

	// Hard reset reloads the stored configuration, so masks return to defaults
	assign hard_clear = hard_reload;

	always_ff @(posedge aclk) begin
		if (!aresetn || hard_clear) begin
			dev_mask <= cff_pkg::RST_MASK;
		end else if (wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_DEV_MASK)) begin
			dev_mask <= rb.wr_data & cff_pkg::DEV_MASK_USED;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hard_clear) begin
			in_mask <= cff_pkg::RST_MASK;
		end else if (wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_IN_MASK)) begin
			in_mask <= rb.wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hard_clear) begin
			loop_mask <= cff_pkg::RST_MASK;
		end else if (wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_LOOP_MASK)) begin
			loop_mask <= rb.wr_data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hard_clear) begin
			cal_mask <= cff_pkg::RST_MASK[7:cff_pkg::CAL_LO];
		end else if (wr_to(rb.wr_en, rb.wr_idx, cff_pkg::IDX_CAL_MASK)) begin
			cal_mask <= rb.wr_data[7:cff_pkg::CAL_LO];
		end
	end

	// Interrupt gating; a one in a mask bit hides its flag
	assign dev_pending = device_sticky_flags & ~dev_mask & cff_pkg::DEV_MASK_USED;
	assign in_pending = input_sticky_flags & ~in_mask;
	assign loop_pending = loop_flags & ~loop_mask;
	assign cal_pending = cal_flags & ~cal_mask;
	assign next_irq = |{dev_pending, in_pending, loop_pending, cal_pending};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_out_n <= 1'b1;
		end else begin
			irq_out_n <= !next_irq;
		end
	end

	// Strobe bits never hold state; a written one is one pulse
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			device_restart <= 1'b0;
			settings_apply <= 1'b0;
		end else begin
			device_restart <= wr_soft && rb.wr_data[cff_pkg::SR_DEVICE];
			settings_apply <= wr_soft && rb.wr_data[cff_pkg::SR_DEVICE];
		end
	end

	// Loop restarts leave bandwidth alone; software strobes the update itself
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			loop_restart <= 4'h0;
		end else begin
			loop_restart <= wr_soft ? rb.wr_data[cff_pkg::SR_LOOP_LO +: 4] : 4'h0;
		end
	end

	// Each write of a one is a rising edge since the bit self-clears
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			step_up_strobe <= 3'h0;
			step_down_strobe <= 3'h0;
		end else begin
			step_up_strobe <= {3{wr_step && rb.wr_data[cff_pkg::STEP_UP_BIT]}}
				& ~step_block_bits;
			step_down_strobe <= {3{wr_step && rb.wr_data[cff_pkg::STEP_DOWN_BIT]}}
				& ~step_block_bits;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || hard_clear) begin
			low_current_sleep <= cff_pkg::RST_SLEEP;
		end else if (wr_ctrl) begin
			low_current_sleep <= rb.wr_data[cff_pkg::CTL_SLEEP];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hard_reload <= 1'b0;
		end else begin
			hard_reload <= wr_ctrl && rb.wr_data[cff_pkg::CTL_HARD];
		end
	end

	// Software bit and the low pin have the same effect
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divider_align <= 1'b0;
		end else begin
			divider_align <= (wr_ctrl && rb.wr_data[cff_pkg::CTL_ALIGN]) || !align_pin_n_s;
		end
	end

	// Read decode; strobe registers read as zero
	always_comb begin
		rb.rd_data = 8'h00;
		unique case (rb.rd_idx)
			cff_pkg::IDX_LOOP_FLAGS: rb.rd_data = loop_flags;
			cff_pkg::IDX_CAL_FLAGS: rb.rd_data = {cal_flags, 4'h0};
			cff_pkg::IDX_DEV_MASK: rb.rd_data = dev_mask;
			cff_pkg::IDX_IN_MASK: rb.rd_data = in_mask;
			cff_pkg::IDX_LOOP_MASK: rb.rd_data = loop_mask;
			cff_pkg::IDX_CAL_MASK: rb.rd_data = {cal_mask, 4'h0};
			cff_pkg::IDX_CTRL: rb.rd_data = {7'h00, low_current_sleep};
			default: rb.rd_data = 8'h00;
		endcase
	end

	a_loop_irq: assert property (@(posedge aclk) disable iff (!aresetn)
		(loop_flags & ~loop_mask) != 8'h00 |=> !irq_out_n)
		else $error("unmasked loop flag did not raise the interrupt");
	a_irq_release: assert property (@(posedge aclk) disable iff (!aresetn)
		!next_irq |=> irq_out_n)
		else $error("interrupt held with no unmasked flag");
	a_dev_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(device_sticky_flags & ~dev_mask & cff_pkg::DEV_MASK_USED) != 8'h00 |=> !irq_out_n)
		else $error("unmasked device flag did not raise the interrupt");
	a_input_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(input_sticky_flags & ~in_mask) != 8'h00 |=> !irq_out_n)
		else $error("unmasked input flag did not raise the interrupt");
	a_cal_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(cal_flags & ~cal_mask) != 4'h0 |=> !irq_out_n)
		else $error("unmasked calibration flag did not raise the interrupt");
	a_unlock_track: assert property (@(posedge aclk) disable iff (!aresetn)
		unlocked != 4'h0 |-> ##3 ((loop_flags[3:0] & $past(unlocked, 3)) == $past(unlocked, 3)))
		else $error("unlock flag not set three cycles after live unlock");
	a_restart_once: assert property (@(posedge aclk) disable iff (!aresetn)
		device_restart |-> settings_apply ##1 !device_restart)
		else $error("device restart not a single pulse with settings apply");
	a_loop_no_apply: assert property (@(posedge aclk) disable iff (!aresetn)
		(loop_restart != 4'h0) && !device_restart |-> !settings_apply)
		else $error("loop restart applied bandwidth settings");
	a_step_blocked: assert property (@(posedge aclk) disable iff (!aresetn)
		(step_up_strobe | step_down_strobe) != 3'h0 |->
		((step_up_strobe | step_down_strobe) & $past(step_block_bits)) == 3'h0)
		else $error("step strobe reached a blocked loop");
	a_sleep_set: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl && rb.wr_data[0] && !hard_reload |=> low_current_sleep)
		else $error("sleep bit not taken from control write");

	// Pulse widths, the align pin and the other live flag groups
	a_loop_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		loop_restart != 4'h0 |=> loop_restart == 4'h0)
		else $error("loop restart lasted more than one cycle");
	a_step_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
		(step_up_strobe | step_down_strobe) != 3'h0 |=>
		(step_up_strobe | step_down_strobe) == 3'h0)
		else $error("step strobe lasted more than one cycle");
	a_soft_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_soft && !rb.wr_data[cff_pkg::SR_DEVICE] |=> !device_restart)
		else $error("device restart without a written one");
	a_hard_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
		hard_reload |=> !hard_reload && dev_mask == cff_pkg::RST_MASK
		&& low_current_sleep == cff_pkg::RST_SLEEP)
		else $error("hard reload did not restore defaults in one pulse");
	a_sleep_clear: assert property (@(posedge aclk) disable iff (!aresetn)
		wr_ctrl && !rb.wr_data[cff_pkg::CTL_SLEEP] |=> !low_current_sleep)
		else $error("sleep bit not cleared by control write");
	a_align_pin: assert property (@(posedge aclk) disable iff (!aresetn)
		!align_pin_n_s |=> divider_align)
		else $error("align output missed the low pin");
	a_align_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		align_pin_n_s && !wr_ctrl |=> !divider_align)
		else $error("align output without pin or write");
	a_hold_track: assert property (@(posedge aclk) disable iff (!aresetn)
		holdover != 4'h0 |-> ##3 ((loop_flags[7:4] & $past(holdover, 3)) == $past(holdover, 3)))
		else $error("holdover flag not set three cycles after live holdover");
	a_cal_track: assert property (@(posedge aclk) disable iff (!aresetn)
		calibrating != 4'h0 |-> ##3
		((cal_flags & $past(calibrating, 3)) == $past(calibrating, 3)))
		else $error("calibration flag not set three cycles after live busy");
	a_flag_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		!wr_loop_flags |=> (loop_flags & $past(loop_flags)) == $past(loop_flags))
		else $error("loop flag fell with no clearing write");
endmodule : cff_top

//--- testbench.sv
// Self-checking bench for the loop fault flag register block
`timescale 1ns/1ps
module testbench;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [cff_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = '0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [cff_pkg::ADDR_W-1:0] s_axi_araddr = '0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic [3:0] unlocked = 4'h0;
	logic [3:0] holdover = 4'h0;
	logic [3:0] calibrating = 4'h0;
	logic divider_align_pin_n = 1'b1;
	logic [7:0] device_sticky_flags = 8'h00;
	logic [7:0] input_sticky_flags = 8'h00;
	logic [2:0] step_block_bits = 3'h0;
	logic irq_out_n, device_restart, settings_apply, low_current_sleep, hard_reload, divider_align;
	logic [3:0] loop_restart;
	logic [2:0] step_up_strobe, step_down_strobe;
	logic watch = 1'b1;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [13:0] sq[$];
	logic [13:0] stv;
	logic [31:0] r;
	logic [3:0] strb = 4'hf;
	int bad_count = 0;
	int comparisons = 0;

	cff_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .unlocked(unlocked), .holdover(holdover),
		.calibrating(calibrating), .divider_align_pin_n(divider_align_pin_n),
		.device_sticky_flags(device_sticky_flags), .input_sticky_flags(input_sticky_flags),
		.step_block_bits(step_block_bits), .irq_out_n(irq_out_n), .device_restart(device_restart),
		.settings_apply(settings_apply), .loop_restart(loop_restart),
		.step_up_strobe(step_up_strobe), .step_down_strobe(step_down_strobe),
		.low_current_sleep(low_current_sleep), .hard_reload(hard_reload),
		.divider_align(divider_align));

	always #25 aclk = ~aclk;

	assign stv = {device_restart, settings_apply, loop_restart, step_up_strobe, step_down_strobe,
		hard_reload, divider_align};

	task automatic summarize();
		$display("Summary: %0d mismatches in %0d comparisons", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [33:0] got, input logic [33:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic hang();
		bad_count++;
		$display("ERROR %0t: bus answer never came", $time);
		summarize();
	endtask : hang

	// Address and data stay up until each channel's own ready edge
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] resp);
		logic aw_ok, w_ok, b_ok;
		int n;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		b_ok = 1'b0;
		bq.push_back(resp);
		@(posedge aclk);
		s_axi_awaddr <= {4'h0, idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= strb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !(aw_ok && w_ok); n++) begin
			@(negedge aclk);
			if (s_axi_awvalid && s_axi_awready === 1'b1) aw_ok = 1'b1;
			if (s_axi_wvalid && s_axi_wready === 1'b1) w_ok = 1'b1;
			@(posedge aclk);
			if (aw_ok) s_axi_awvalid <= 1'b0;
			if (w_ok) s_axi_wvalid <= 1'b0;
		end
		for (n = 0; n < 50 && !b_ok; n++) begin
			@(negedge aclk);
			b_ok = (s_axi_bvalid === 1'b1);
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
		if (!b_ok) hang();
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] resp);
		logic a_ok, r_ok;
		int n;
		a_ok = 1'b0;
		r_ok = 1'b0;
		rq.push_back({resp, 24'h0, d});
		@(posedge aclk);
		s_axi_araddr <= {4'h0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !r_ok; n++) begin
			@(negedge aclk);
			if (s_axi_arvalid && s_axi_arready === 1'b1) a_ok = 1'b1;
			r_ok = (s_axi_rvalid === 1'b1);
			@(posedge aclk);
			if (a_ok) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		if (!r_ok) hang();
	endtask : rd

	// Live inputs pass a synchroniser, so allow a few edges before looking
	task automatic irq_is(input logic exp);
		repeat (6) @(posedge aclk);
		@(negedge aclk);
		chk({33'h0, irq_out_n}, {33'h0, exp}, "interrupt level");
	endtask : irq_is

	always @(posedge aclk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
			if (rq.size() == 0) chk(34'h1, 34'h0, "unexpected read answer");
			else chk({s_axi_rresp, s_axi_rdata}, rq.pop_front(), "read");
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
			if (bq.size() == 0) chk(34'h1, 34'h0, "unexpected write answer");
			else chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()}, "write response");
		end
		if (aresetn && watch && stv !== 14'h0) begin
			if (sq.size() == 0) chk({20'h0, stv}, 34'h0, "unexpected strobe");
			else chk({20'h0, stv}, {20'h0, sq.pop_front()}, "strobe outputs");
		end
	end

	initial begin
		void'($urandom(32'h31742bbd));
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		irq_is(1'b1);
		rd(cff_pkg::IDX_LOOP_MASK, cff_pkg::RST_MASK, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_LOOP_FLAGS, cff_pkg::RST_FLAGS, cff_pkg::RESP_OKAY);
		rd(6'h15, 8'h00, cff_pkg::RESP_SLVERR);
		wr(6'h15, 8'hff, cff_pkg::RESP_SLVERR);
		r = $urandom;
		wr(cff_pkg::IDX_DEV_MASK, r[7:0], cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_DEV_MASK, r[7:0] & cff_pkg::DEV_MASK_USED, cff_pkg::RESP_OKAY);
		r = $urandom;
		wr(cff_pkg::IDX_IN_MASK, r[7:0], cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_IN_MASK, r[7:0], cff_pkg::RESP_OKAY);
		// Lane 0 unstrobed: answered OKAY but nothing lands
		strb = {r[11:9], 1'b0};
		wr(cff_pkg::IDX_IN_MASK, ~r[7:0], cff_pkg::RESP_OKAY);
		strb = {r[14:12], 1'b1};
		rd(cff_pkg::IDX_IN_MASK, r[7:0], cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_DEV_MASK, 8'h00, cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_IN_MASK, 8'h00, cff_pkg::RESP_OKAY);
		unlocked <= 4'b0010;
		holdover <= 4'b0100;
		irq_is(1'b0);
		rd(cff_pkg::IDX_LOOP_FLAGS, 8'h42, cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_LOOP_FLAGS, 8'h00, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_LOOP_FLAGS, 8'h42, cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_LOOP_MASK, 8'h42, cff_pkg::RESP_OKAY);
		irq_is(1'b1);
		wr(cff_pkg::IDX_LOOP_MASK, 8'h02, cff_pkg::RESP_OKAY);
		irq_is(1'b0);
		unlocked <= 4'b0000;
		holdover <= 4'b0000;
		repeat (6) @(posedge aclk);
		wr(cff_pkg::IDX_LOOP_FLAGS, 8'h40, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_LOOP_FLAGS, 8'h40, cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_LOOP_FLAGS, 8'h00, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_LOOP_FLAGS, 8'h00, cff_pkg::RESP_OKAY);
		irq_is(1'b1);
		calibrating <= 4'b1000;
		irq_is(1'b0);
		rd(cff_pkg::IDX_CAL_FLAGS, 8'h80, cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_CAL_MASK, 8'h80, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_CAL_MASK, 8'h80, cff_pkg::RESP_OKAY);
		irq_is(1'b1);
		calibrating <= 4'b0000;
		repeat (6) @(posedge aclk);
		wr(cff_pkg::IDX_CAL_FLAGS, 8'h00, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_CAL_FLAGS, 8'h00, cff_pkg::RESP_OKAY);
		device_sticky_flags <= 8'h20;
		irq_is(1'b0);
		wr(cff_pkg::IDX_DEV_MASK, 8'h20, cff_pkg::RESP_OKAY);
		irq_is(1'b1);
		input_sticky_flags <= 8'h81;
		irq_is(1'b0);
		wr(cff_pkg::IDX_IN_MASK, 8'h81, cff_pkg::RESP_OKAY);
		irq_is(1'b1);
		sq.push_back(14'h3000);
		wr(cff_pkg::IDX_SOFT_RST, 8'h01, cff_pkg::RESP_OKAY);
		sq.push_back(14'h0f00);
		wr(cff_pkg::IDX_SOFT_RST, 8'h1e, cff_pkg::RESP_OKAY);
		sq.push_back(14'h00e0);
		wr(cff_pkg::IDX_STEP, 8'h01, cff_pkg::RESP_OKAY);
		r = $urandom;
		step_block_bits <= r[2:0] & 3'b110;
		sq.push_back({9'h000, ~(r[2:0] & 3'b110), 2'h0});
		wr(cff_pkg::IDX_STEP, 8'h02, cff_pkg::RESP_OKAY);
		wr(cff_pkg::IDX_CTRL, 8'h01, cff_pkg::RESP_OKAY);
		chk({33'h0, low_current_sleep}, 34'h1, "sleep level");
		rd(cff_pkg::IDX_CTRL, 8'h01, cff_pkg::RESP_OKAY);
		sq.push_back(14'h0002);
		wr(cff_pkg::IDX_CTRL, 8'h02, cff_pkg::RESP_OKAY);
		rd(cff_pkg::IDX_DEV_MASK, cff_pkg::RST_MASK, cff_pkg::RESP_OKAY);
		sq.push_back(14'h0001);
		wr(cff_pkg::IDX_CTRL, 8'h04, cff_pkg::RESP_OKAY);
		repeat (3) @(posedge aclk);
		// The pin holds the align output as a level, outside the strobe queue
		watch <= 1'b0;
		divider_align_pin_n <= 1'b0;
		repeat (6) @(posedge aclk);
		chk({33'h0, divider_align}, 34'h1, "align from pin");
		divider_align_pin_n <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(rq.size() + bq.size() + sq.size(), 34'h0, "answers left over");
		summarize();
	end
endmodule : testbench
